// ===== src/tw_target.sv
// Two-wire bus target front end: framing, addressing, acknowledge.
// Assumes pins arrive asynchronously; a user side feeds and takes bytes.
`timescale 1ns/1ps
`default_nettype none
module tw_target
    import tw_pkg::*;
#(
    parameter int TIMEOUT_CYC = tw_pkg::TOUT_CYC,
    parameter int FILTER_CYC = tw_pkg::GLITCH_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic rx_accept,
    input wire logic busy,
    output logic [7:0] rx_data,
    output logic rx_strobe,
    output logic [3:0] sel_type,
    output logic sel_read,
    output logic sel_strobe,
    output logic tx_take,
    output logic active,
    output logic standby
);
    import tw_pkg::*;
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    // Counter value after the acknowledge clock's rising edge.
    localparam logic [3:0] BIT_END = BIT_ACK + 4'h1;

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
    tw_state_t state;
    tw_state_t next_state;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic [7:0] tx_shift;
    logic pull_low;
    logic ack_now;
    logic [TW-1:0] low_count;
    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    logic stopped;

    // ==========================================================
    // Line conditioning. The clock line is sampled only, never driven.
    // Both lines share one filter length so their events keep their order.
    tw_sync_filter #(.FILTER_CYC(FILTER_CYC), .RESET_LEVEL(1'b1)) u_scl_filt (
        .clk(clk),
        .reset(reset),
        .pin(scl_in),
        .filtered(scl)
    );
    tw_sync_filter #(.FILTER_CYC(FILTER_CYC), .RESET_LEVEL(1'b1)) u_sda_filt (
        .clk(clk),
        .reset(reset),
        .pin(sda_in),
        .filtered(sda)
    );
    tw_edge_detect u_scl_edge (
        .clk(clk),
        .reset(reset),
        .level(scl),
        .rise(scl_rise),
        .fall(scl_fall)
    );
    tw_edge_detect u_sda_edge (
        .clk(clk),
        .reset(reset),
        .level(sda),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // ==========================================================
    // Select pins are static straps, but they still pass two flip-flops so
    // that a strap changed while powered cannot upset the address compare.
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_meta <= '0;
            sel_sync <= '0;
        end else begin
            sel_meta <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
            sel_sync <= sel_meta;
        end
    end

    // ==========================================================
    // Bus conditions, judged on the filtered lines.
    // A spike shorter than the filter span therefore never ends a frame.
    wire start_cond = sda_fall & scl;
    wire stop_cond = sda_rise & scl;
    wire bus_idle = scl & sda;
    wire timed_out = (low_count == TW'(TIMEOUT_CYC));
    wire abort = stop_cond | timed_out;
    wire [6:0] my_addr = {4'h0, sel_sync};
    wire [7:0] addr_byte = {shift[6:0], sda};
    wire type_ok = (addr_byte[7:4] == TYPE_MEMORY) || (addr_byte[7:4] == TYPE_PAGE);
    wire addr_hit = type_ok && (addr_byte[3:1] == my_addr[2:0]);
    wire byte_done = scl_rise && (bit_count == BIT_LAST_DATA);
    wire ack_edge = scl_rise && (bit_count == BIT_ACK);
    wire in_frame = (state != TW_IDLE) && (state != TW_WAIT);
    // Slot decodes: the acknowledge clock, the frame's end, and receive phases.
    wire ack_slot = (bit_count == BIT_ACK);
    wire frame_end = (bit_count == BIT_END);
    wire rx_side = (state == TW_ADDR) || (state == TW_RECV);

    assign sda_out = 1'b0;
    assign sda_oe = pull_low;
    assign active = in_frame;
    assign standby = stopped & ~busy & bus_idle;

    // ==========================================================
    // Transaction phase after each start, address and acknowledge.
    // A start wins over everything, which makes a repeated start and a start
    // in mid-byte the same case.
    always_comb begin
        next_state = state;
        if (start_cond) begin
            next_state = TW_ADDR;
        end else if (abort) begin
            next_state = TW_IDLE;
        end else begin
            case (state)
                TW_IDLE: next_state = TW_IDLE;
                TW_WAIT: next_state = TW_WAIT;
                TW_ADDR: begin
                    if (byte_done && !addr_hit) begin
                        next_state = TW_WAIT;
                    end else if (ack_edge) begin
                        next_state = sel_read ? TW_SEND : TW_RECV;
                    end
                end
                TW_RECV: next_state = TW_RECV;
                TW_SEND: begin
                    if (ack_edge && sda) begin
                        next_state = TW_WAIT;
                    end
                end
                default: next_state = TW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= TW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Bit counter: counts rising clock edges of the frame. It reads 8 in the
    // acknowledge clock's low phase and 9 in its high phase, and wraps on the
    // falling edge that closes the ninth clock. Counting rises, not falls,
    // keeps the start condition's own falling edge out of the count.
    always_ff @(posedge clk) begin
        if (reset || start_cond || abort) begin
            bit_count <= '0;
        end else if (in_frame && scl_fall && frame_end) begin
            bit_count <= '0;
        end else if (in_frame && scl_rise && bit_count < BIT_END) begin
            bit_count <= bit_count + 4'h1;
        end
    end

    // Receive shifter samples on the rising edge, first bit ends at the top.
    // Bits past the eighth are not shifted, so the acknowledge stays out.
    always_ff @(posedge clk) begin
        if (reset) begin
            shift <= '0;
        end else if (in_frame && scl_rise && bit_count <= BIT_LAST_DATA) begin
            shift <= {shift[6:0], sda};
        end
    end

    // ==========================================================
    // Address decode and receive hand-off.
    // A foreign address leaves the select outputs at their last value.
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_type <= '0;
            sel_read <= 1'b0;
            sel_strobe <= 1'b0;
            rx_data <= '0;
            rx_strobe <= 1'b0;
        end else begin
            sel_strobe <= 1'b0;
            rx_strobe <= 1'b0;
            if (state == TW_ADDR && byte_done && addr_hit) begin
                sel_type <= addr_byte[7:4];
                sel_read <= addr_byte[0];
                sel_strobe <= 1'b1;
            end else if (state == TW_RECV && byte_done) begin
                rx_data <= addr_byte;
                rx_strobe <= 1'b1;
            end
        end
    end

    // Acknowledge choice is made at the eighth rising edge, used at the fall.
    // A refused data byte and a foreign address both leave the line released.
    always_ff @(posedge clk) begin
        if (reset || start_cond) begin
            ack_now <= 1'b0;
        end else if (byte_done && state == TW_ADDR) begin
            ack_now <= addr_hit;
        end else if (byte_done && state == TW_RECV) begin
            ack_now <= rx_accept;
        end else if (byte_done) begin
            ack_now <= 1'b0;
        end
    end

    // ==========================================================
    // Transmit: load on the acknowledge fall, shift on each later fall.
    // A missing byte sends all ones, which leaves the line released.
    // The byte is taken on the falling edge that closes the acknowledge clock.
    wire load_tx = scl_fall && frame_end && (next_state == TW_SEND) && !abort;
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_shift <= 8'hff;
            tx_take <= 1'b0;
        end else begin
            tx_take <= 1'b0;
            if (load_tx) begin
                tx_shift <= tx_valid ? tx_data : 8'hff;
                tx_take <= tx_valid;
            end else if (scl_fall && state == TW_SEND && bit_count <= BIT_LAST_DATA) begin
                tx_shift <= {tx_shift[6:0], 1'b1};
            end
        end
    end

    // ==========================================================
    // Line driver: changes only on falling clock edges, released on start or abort.
    // The pull moves one cycle after the filtered fall, well inside the low
    // phase, so the controller always samples a settled line at the next rise.
    always_ff @(posedge clk) begin
        if (reset || start_cond || abort) begin
            pull_low <= 1'b0;
        end else if (scl_fall) begin
            if (ack_slot && rx_side) begin
                pull_low <= ack_now;
            end else if (load_tx) begin
                pull_low <= tx_valid & ~tx_data[7];
            end else if (state == TW_SEND && bit_count <= BIT_LAST_DATA) begin
                pull_low <= ~tx_shift[6];
            end else begin
                pull_low <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Clock-low watchdog and standby tracking.
    // The watchdog runs in every phase, idle included, so a bus stuck low
    // also clears a half-received address.
    always_ff @(posedge clk) begin
        if (reset || scl) begin
            low_count <= '0;
        end else if (!timed_out) begin
            low_count <= low_count + TW'(1);
        end
    end

    // Standby follows a stop, a foreign address, a refused read byte or a timeout, then waits for busy.
    always_ff @(posedge clk) begin
        if (reset) begin
            stopped <= 1'b1;
        end else if (start_cond) begin
            stopped <= 1'b0;
        end else if (abort || state == TW_WAIT) begin
            stopped <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== src/tw_pkg.sv
// Constants for the two-wire target front end.
// Assumes a 200 MHz system clock sampling the bus pins.
package tw_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 200;
    // Glitch filter span, in nanoseconds; spikes shorter are dropped.
    localparam int GLITCH_NS = 50;
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    // Clock-low timeout, least figure, in microseconds.
    localparam int TOUT_US = 25;
    localparam int TOUT_CYC = TOUT_US * CLK_MHZ;
    // ==========================================================
    // Frame layout
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Type identifiers in the upper nibble of the address byte.
    localparam logic [3:0] TYPE_MEMORY = 4'ha;
    localparam logic [3:0] TYPE_PAGE = 4'h6;
    // Transaction phases.
    typedef enum logic [4:0] {
        TW_IDLE = 5'h01,
        TW_ADDR = 5'h02,
        TW_RECV = 5'h04,
        TW_SEND = 5'h08,
        TW_WAIT = 5'h10
    } tw_state_t;
endpackage

// ===== src/tw_sync_filter.sv
// Two-stage synchroniser followed by a majority-free hold filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tw_sync_filter #(
    parameter int FILTER_CYC = 10,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    output logic filtered
);
    localparam int CW = $clog2(FILTER_CYC + 1);
    logic meta;
    logic sync;
    logic [CW-1:0] count;
    wire differs = (sync != filtered);
    wire settled = (count == CW'(FILTER_CYC));

    // ==========================================================
    // Synchroniser; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= RESET_LEVEL;
            sync <= RESET_LEVEL;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end

    // A new level must persist for FILTER_CYC + 1 cycles to be accepted.
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= '0;
            filtered <= RESET_LEVEL;
        end else if (!differs) begin
            count <= '0;
        end else if (settled) begin
            count <= '0;
            filtered <= sync;
        end else begin
            count <= count + CW'(1);
        end
    end
endmodule
`default_nettype wire

// ===== src/tw_edge_detect.sv
// Edge finder for one filtered bus line.
// Assumes a filtered, already synchronous input.
`timescale 1ns/1ps
`default_nettype none
module tw_edge_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev;

    // ==========================================================
    // Previous sample; reset high matches an idle bus.
    always_ff @(posedge clk) begin
        if (reset) begin
            prev <= 1'b1;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule
`default_nettype wire

// ===== dv/tw_target_properties.sv
// Port checker for the two-wire target front end.
// Assumes it is bound onto tw_target and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tw_target_properties
    import tw_pkg::*;
#(
    parameter int TIMEOUT_CYC = 50,
    parameter int FILTER_CYC = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic rx_accept,
    input wire logic busy,
    input wire logic rx_strobe,
    input wire logic [3:0] sel_type,
    input wire logic sel_strobe,
    input wire logic active,
    input wire logic standby
);
    // ==========================================================
    // Helper logic
    // Counts clock-low cycles; the margin covers sync and filter delay.
    logic [15:0] low_cnt;
    always_ff @(posedge clk) begin
        if (reset || scl_in) begin
            low_cnt <= 16'h0000;
        end else if (low_cnt != 16'hffff) begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_took_byte;
        rx_strobe && rx_accept;
    endsequence
    sequence s_pull_soon;
        ##[1:20] sda_oe;
    endsequence
    // ==========================================================
    // Assertions
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    AST_RESET_IDLE: assert property ($fell(reset) |-> !sda_oe && !active && !rx_strobe)
        else $error("not idle after reset");
    AST_DRIVE_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("pull started while clock high");
    AST_STEADY_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data changed while clock high");
    AST_TYPE_MATCH: assert property (sel_strobe |-> ##1 (sel_type == TYPE_MEMORY ||
        sel_type == TYPE_PAGE))
        else $error("selected an unknown type");
    AST_ADDR_ACK: assert property (sel_strobe |-> s_pull_soon)
        else $error("no acknowledge for address");
    AST_DATA_ACK: assert property (s_took_byte |-> s_pull_soon)
        else $error("no acknowledge for data");
    AST_DATA_NACK: assert property (rx_strobe && !rx_accept |-> !sda_oe [*8] ##1 !sda_oe [*8])
        else $error("refused byte acknowledged");
    AST_TIMEOUT: assert property (low_cnt == 16'(TIMEOUT_CYC + FILTER_CYC + 12)
        |-> !sda_oe && !active)
        else $error("no release after clock timeout");
    AST_STANDBY: assert property (standby |-> !busy && !active)
        else $error("standby while busy or active");
    AST_STANDBY_ENTRY: assert property ($fell(active) && !busy && scl_in && sda_in
        |-> ##[1:20] standby)
        else $error("no standby after a released idle bus");
endmodule
bind tw_target tw_target_properties #(.TIMEOUT_CYC(TIMEOUT_CYC), .FILTER_CYC(FILTER_CYC)) u_props (
    .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .rx_accept(rx_accept), .busy(busy), .rx_strobe(rx_strobe),
    .sel_type(sel_type), .sel_strobe(sel_strobe), .active(active), .standby(standby));
`default_nettype wire

// ===== dv/tw_ctrl_model.sv
// Behavioural bus controller driving clock and data at a 48 ns period.
// Assumes the bench resolves the pulled-up data line from all pulls.
`timescale 1ns/1ps
`default_nettype none
module tw_ctrl_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Bus idles with both lines high.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One bit: data moves mid-low, sampled at the rise; low phase is long
    // so the filtered device answer settles before the clock rises.
    task automatic bit_io(input logic b, output logic s);
        #8 sda_low = ~b;
        #24 scl = 1'b1;
        s = sda;
        #16 scl = 1'b0;
    endtask
    // Byte out plus the ninth clock with the line released.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // Byte in, then answer acknowledge or not.
    task automatic rd_byte(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack, s);
    endtask
    // Start or repeated start: data falls while clock high.
    task automatic start();
        #8 sda_low = 1'b0;
        #16 scl = 1'b1;
        #16 sda_low = 1'b1;
        #24 scl = 1'b0;
    endtask
    // Stop: data rises while clock high, leaving the bus idle.
    task automatic stop();
        #8 sda_low = 1'b1;
        #16 scl = 1'b1;
        #16 sda_low = 1'b0;
        #16;
    endtask
endmodule
`default_nettype wire

// ===== dv/tw_target_tb.sv
// Self-checking bench for the two-wire target front end.
// Assumes tw_ctrl_model as controller and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t value %0h expected %0h", $time, (a), (e)); end end
module tw_target_tb;
    import tw_pkg::*;
    logic clk;
    logic reset;
    logic scl;
    logic sda_low;
    wire logic sda_bus;
    logic sda_out, sda_oe, active, standby, rx_strobe, sel_strobe, tx_take, sel_read;
    logic tx_valid, rx_accept, busy, ack;
    logic [2:0] sel_bits;
    logic [3:0] sel_type;
    logic [7:0] tx_data, rx_data, last_rx, d;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_rx = 0;
    int n_take = 0;
    // Pull-up wins unless someone pulls low.
    assign sda_bus = !(sda_low || (sda_oe && !sda_out));
    tw_target #(.TIMEOUT_CYC(50), .FILTER_CYC(1)) u_dut (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_bit2(sel_bits[2]), .addr_select_bit1(sel_bits[1]),
        .addr_select_bit0(sel_bits[0]), .tx_data(tx_data), .tx_valid(tx_valid),
        .rx_accept(rx_accept), .busy(busy), .rx_data(rx_data), .rx_strobe(rx_strobe),
        .sel_type(sel_type), .sel_read(sel_read), .sel_strobe(sel_strobe),
        .tx_take(tx_take), .active(active), .standby(standby));
    tw_ctrl_model u_ctl (.scl(scl), .sda_low(sda_low), .sda(sda_bus));
    // Strobes last one cycle, so catch them on every edge.
    always @(posedge clk) begin
        if (rx_strobe) begin
            last_rx <= rx_data;
            n_rx <= n_rx + 1;
        end
        if (tx_take) begin
            n_take <= n_take + 1;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic addr(input logic [3:0] t, input logic rd, input logic exp);
        u_ctl.wr_byte({t, sel_bits, rd}, ack);
        `CHK(ack, exp)
    endtask
    task automatic t_write();
        `CHK(standby, 1'b1)
        u_ctl.start();
        addr(TYPE_MEMORY, 1'b0, 1'b1);
        `CHK(sel_type, TYPE_MEMORY)
        u_ctl.wr_byte(8'ha5, ack);
        `CHK(ack, 1'b1)
        `CHK(last_rx, 8'ha5)
        cyc(1);
        rx_accept = 1'b0;
        u_ctl.wr_byte(8'h0f, ack);
        `CHK(ack, 1'b0)
        `CHK(n_rx, 2)
        cyc(1);
        busy = 1'b1;
        u_ctl.stop();
        cyc(20);
        `CHK(active, 1'b0)
        `CHK(standby, 1'b0)
        busy = 1'b0;
        rx_accept = 1'b1;
        cyc(4);
        `CHK(standby, 1'b1)
    endtask
    task automatic t_badaddr();
        u_ctl.start();
        addr(4'h3, 1'b0, 1'b0);
        u_ctl.wr_byte(8'h00, ack);
        `CHK(ack, 1'b0)
        `CHK(n_rx, 2)
        u_ctl.stop();
    endtask
    task automatic t_read();
        cyc(1);
        tx_data = 8'h96;
        tx_valid = 1'b1;
        u_ctl.start();
        addr(TYPE_PAGE, 1'b0, 1'b1);
        `CHK(sel_type, TYPE_PAGE)
        u_ctl.start();
        addr(TYPE_MEMORY, 1'b1, 1'b1);
        `CHK(sel_read, 1'b1)
        fork
            u_ctl.rd_byte(d, 1'b1);
            begin
                wait (n_take == 1);
                @(negedge clk);
                tx_data = 8'h5a;
            end
        join
        `CHK(d, 8'h96)
        u_ctl.rd_byte(d, 1'b0);
        `CHK(d, 8'h5a)
        cyc(10);
        `CHK(sda_oe, 1'b0)
        `CHK(n_take, 2)
        u_ctl.stop();
    endtask
    task automatic t_midbyte();
        logic s;
        cyc(1);
        sel_bits = 3'b010;
        cyc(4);
        u_ctl.start();
        addr(TYPE_MEMORY, 1'b0, 1'b1);
        repeat (4) u_ctl.bit_io(1'b0, s);
        u_ctl.stop();
        cyc(10);
        `CHK(active, 1'b0)
        u_ctl.start();
        addr(TYPE_MEMORY, 1'b0, 1'b1);
        u_ctl.stop();
    endtask
    task automatic t_timeout();
        cyc(1);
        tx_data = 8'h00;
        u_ctl.start();
        addr(TYPE_MEMORY, 1'b1, 1'b1);
        cyc(10);
        `CHK(sda_oe, 1'b1)
        #400;
        `CHK(sda_oe, 1'b0)
        `CHK(active, 1'b0)
        u_ctl.stop();
        u_ctl.start();
        addr(TYPE_MEMORY, 1'b0, 1'b1);
        u_ctl.stop();
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // A full run takes about 8 us; ten times that means a hang.
    initial begin
        #80000;
        n_mismatch++;
        final_report();
    end
    // Main sequence.
    initial begin
        reset = 1'b1;
        sel_bits = 3'b101;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        rx_accept = 1'b1;
        busy = 1'b0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        cyc(10);
        t_write();
        t_badaddr();
        t_read();
        t_midbyte();
        t_timeout();
        final_report();
    end
endmodule
`default_nettype wire
